// file: rtl/uml_port.sv
/*
  Serial port status and modem control block: register port, modem lines, loopback,
  line status, modem status, scratch byte with soft reset, transmitter and receiver.
  Assumes a one-cycle register port without wait states and pins synchronous to clk.
*/
// The plain strobed port and the register addresses are this design's own decisions.
// Functional notes
// R01 - control bit 0 drives terminal-ready pin level
// R02 - control bit 1 drives send-request pin level
// R03 - bits 2,3 are read-write user flags, bit 3 also sets carrier level in loopback
// R04 - control bit 4 selects loopback test mode
// R05 - control bits 31:5 read as zero
// R06 - status bit 0 shows receive buffer full
// R07 - status bit 1 flags receive overrun
// R08 - status bit 2 flags parity error
// R09 - status bit 3 flags framing error
// R10 - status bit 4 flags received break
// R11 - status bit 5 shows holding register empty
// R12 - status bit 6 shows holding and shifter empty
// R13 - status bit 7 flags error in buffer
// R14 - modem change flags set, cleared on read
// R15 - ring edge flag never set
// R16 - send-ready level, loopback uses control bit 1
// R17 - set-ready level, loopback uses control bit 0
// R18 - carrier level, loopback uses control bit 3
// R19 - ring level always reads zero
// R20 - scratch byte stores any value
// R21 - scratch bit 8 holds port in reset
// R22 - bit time is divisor times 128 clocks
// R23 - divisor access bit remaps shared offset
// R24 - loopback wires transmitter to receiver internally
`timescale 1ns/1ps
module uml_port #(
  parameter logic [15:0] DIV_RESET = uml_pkg::DIV_RST
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [uml_pkg::ADDR_W-1:0] addr,
  input  wire logic [uml_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [uml_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       serial_rx_pin_n,
  output logic                            serial_tx_pin_n,
  input  wire logic                       clear_send_pin_n,
  input  wire logic                       set_ready_pin_n,
  input  wire logic                       carrier_detect_pin_n,
  output logic                            term_ready_pin_n,
  output logic                            send_request_pin_n
);
  logic [uml_pkg::IER_W-1:0] ier_r;
  logic [uml_pkg::DIV_W-1:0] div_r;
  logic [7:0]                lcr_r;
  logic [uml_pkg::MCR_W-1:0] modem_control_r;
  logic [8:0]                scratch_r;
  logic [7:0]                thr_r;
  logic                      thr_full_r;
  logic [7:0]                rbr_r;
  logic                      rx_data_ready_r;
  logic                      overrun_r;
  logic                      rx_parity_error_r;
  logic                      rx_framing_error_r;
  logic                      rx_break_flag_r;
  logic                      rx_queue_error_r;
  logic [2:0]                lvl_prev_r;
  logic                      clear_send_change_r;
  logic                      set_ready_change_r;
  logic                      carrier_detect_change_r;
  logic                      port_rst;
  logic                      loop_on;
  logic                      divisor_access_sel;
  logic                      tx_load;
  logic                      tx_busy;
  logic                      tx_bit;
  logic                      rx_done;
  logic                      rx_in;
  logic                      tx_holding_empty;
  logic                      tx_all_empty;
  logic [2:0]                lvl;
  logic [uml_pkg::CNT_W-1:0] bit_cycles;
  logic [uml_pkg::DIV_W-1:0] div_eff;
  logic [7:0]                line_status;
  logic [7:0]                modem_status;
  logic                      rd_data_q;
  logic                      rd_lsr;
  logic                      rd_msr;
  logic                      wr_thr;
  logic [uml_pkg::DATA_W-1:0] rd_nxt;
  uml_pkg::uml_frame_s       fmt;
  uml_pkg::uml_rx_s          rx_res;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // decode and derived controls
  // R21 soft reset hold
  assign port_rst = rst | scratch_r[uml_pkg::SCR_SRST];
  // R04 loopback select
  assign loop_on  = modem_control_r[uml_pkg::MCR_LOOP];
  assign divisor_access_sel = lcr_r[uml_pkg::LCR_DIV_SEL];
  assign fmt      = uml_pkg::uml_frame_s'(lcr_r[4:0]);
  assign rd_data_q = rd_stb && (addr == uml_pkg::OFS_DATA);
  assign rd_lsr   = rd_stb && (addr == uml_pkg::OFS_LSR);
  assign rd_msr   = rd_stb && (addr == uml_pkg::OFS_MSR);
  assign wr_thr   = wr_stb && (addr == uml_pkg::OFS_DATA);
  assign tx_load  = thr_full_r && !tx_busy;
  // R22 bit time from divisor; a zero divisor behaves as one to avoid a stuck timer
  assign div_eff    = (div_r == '0) ? 16'h0001 : div_r;
  assign bit_cycles = {div_eff, {uml_pkg::BIT_SHIFT{1'b0}}};
  // R24 internal return path
  assign rx_in    = loop_on ? tx_bit : serial_rx_pin_n;

  // ==========================================================================
  // configuration registers, reset only by the hard reset
  always_ff @(posedge clk) begin
    if (rst) begin
      ier_r           <= '0;
      div_r           <= DIV_RESET;
      lcr_r           <= uml_pkg::LCR_RST;
      modem_control_r <= '0;
      scratch_r       <= '0;
    end else if (wr_stb) begin
      unique case (addr)
        // R23 shared offset steering
        uml_pkg::OFS_IER_DIV: begin
          if (divisor_access_sel) div_r <= wr_data[uml_pkg::DIV_W-1:0];
          else ier_r <= wr_data[uml_pkg::IER_W-1:0];
        end
        uml_pkg::OFS_LCR: lcr_r <= wr_data[7:0];
        // R03 user flags stored; bit 3 also feeds loopback carrier
        uml_pkg::OFS_MCR: modem_control_r <= wr_data[uml_pkg::MCR_W-1:0];
        // R20 scratch byte store
        uml_pkg::OFS_SCR: scratch_r <= wr_data[8:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // transmit holding register; a write in the load cycle refills it
  always_ff @(posedge clk) begin
    if (port_rst) begin
      thr_r      <= 8'h00;
      thr_full_r <= 1'b0;
    end else if (wr_thr) begin
      thr_r      <= wr_data[7:0];
      thr_full_r <= 1'b1;
    end else if (tx_load) begin
      thr_full_r <= 1'b0;
    end
  end

  // R11 holding empty flag
  assign tx_holding_empty = !thr_full_r;
  // R12 whole transmitter empty
  assign tx_all_empty     = !thr_full_r && !tx_busy;

  uml_tx u_tx (
    .clk        (clk),
    .rst        (port_rst),
    .bit_cycles (bit_cycles),
    .fmt        (fmt),
    .load       (tx_load),
    .data       (thr_r),
    .busy       (tx_busy),
    .txd        (tx_bit)
  );

  uml_rx u_rx (
    .clk        (clk),
    .rst        (port_rst),
    .bit_cycles (bit_cycles),
    .fmt        (fmt),
    .rxd        (rx_in),
    .done       (rx_done),
    .res        (rx_res)
  );

  // ==========================================================================
  // receive buffer and line status; new events win over read clears
  always_ff @(posedge clk) begin
    if (port_rst) begin
      rbr_r              <= 8'h00;
      rx_data_ready_r    <= 1'b0;
      overrun_r          <= 1'b0;
      rx_parity_error_r  <= 1'b0;
      rx_framing_error_r <= 1'b0;
      rx_break_flag_r    <= 1'b0;
      rx_queue_error_r   <= 1'b0;
    end else begin
      // R06 buffer full level
      if (rx_done) rx_data_ready_r <= 1'b1;
      else if (rd_data_q) rx_data_ready_r <= 1'b0;
      // an overrun keeps the older character, the new one is lost
      if (rx_done && !(rx_data_ready_r && !rd_data_q)) rbr_r <= rx_res.data;
      // R07 overrun detect
      if (rx_done && rx_data_ready_r && !rd_data_q) overrun_r <= 1'b1;
      else if (rd_lsr) overrun_r <= 1'b0;
      // R08 parity flag
      if (rx_done && rx_res.par_err) rx_parity_error_r <= 1'b1;
      else if (rd_lsr) rx_parity_error_r <= 1'b0;
      // R09 framing flag
      if (rx_done && rx_res.frm_err) rx_framing_error_r <= 1'b1;
      else if (rd_lsr) rx_framing_error_r <= 1'b0;
      // R10 break flag
      if (rx_done && rx_res.brk) rx_break_flag_r <= 1'b1;
      else if (rd_lsr) rx_break_flag_r <= 1'b0;
      // R13 buffered character error
      if (rx_done && !(rx_data_ready_r && !rd_data_q)) begin
        rx_queue_error_r <= rx_res.par_err | rx_res.frm_err | rx_res.brk;
      end else if (rd_data_q) begin
        rx_queue_error_r <= 1'b0;
      end
    end
  end

  assign line_status = {rx_queue_error_r, tx_all_empty, tx_holding_empty, rx_break_flag_r,
                        rx_framing_error_r, rx_parity_error_r, overrun_r, rx_data_ready_r};

  // ==========================================================================
  // modem status levels: {carrier, set ready, send ready}
  // R16 R17 R18 levels with loopback
  assign lvl = loop_on ? {modem_control_r[uml_pkg::MCR_FLAG2], modem_control_r[uml_pkg::MCR_TERM],
                          modem_control_r[uml_pkg::MCR_SEND]}
                       : {~carrier_detect_pin_n, ~set_ready_pin_n, ~clear_send_pin_n};

  // R14 change flags, a change in the read cycle survives
  always_ff @(posedge clk) begin
    if (port_rst) begin
      lvl_prev_r              <= 3'b000;
      clear_send_change_r     <= 1'b0;
      set_ready_change_r      <= 1'b0;
      carrier_detect_change_r <= 1'b0;
    end else begin
      lvl_prev_r <= lvl;
      if (lvl[0] != lvl_prev_r[0]) clear_send_change_r <= 1'b1;
      else if (rd_msr) clear_send_change_r <= 1'b0;
      if (lvl[1] != lvl_prev_r[1]) set_ready_change_r <= 1'b1;
      else if (rd_msr) set_ready_change_r <= 1'b0;
      if (lvl[2] != lvl_prev_r[2]) carrier_detect_change_r <= 1'b1;
      else if (rd_msr) carrier_detect_change_r <= 1'b0;
    end
  end

  // R15 R19 ring bits tied low, no ring input exists
  assign modem_status = {lvl[2], 1'b0, lvl[1], lvl[0], carrier_detect_change_r, 1'b0,
                         set_ready_change_r, clear_send_change_r};

  // ==========================================================================
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = '0;
    unique case (addr)
      uml_pkg::OFS_DATA:    rd_nxt[7:0] = rbr_r;
      uml_pkg::OFS_IER_DIV: rd_nxt[uml_pkg::DIV_W-1:0] = divisor_access_sel ? div_r : {12'h000, ier_r};
      uml_pkg::OFS_LCR:     rd_nxt[7:0] = lcr_r;
      // R05 upper control bits zero
      uml_pkg::OFS_MCR:     rd_nxt[uml_pkg::MCR_W-1:0] = modem_control_r;
      uml_pkg::OFS_LSR:     rd_nxt[7:0] = line_status;
      uml_pkg::OFS_MSR:     rd_nxt[7:0] = modem_status;
      uml_pkg::OFS_SCR:     rd_nxt[8:0] = scratch_r;
      default:              rd_nxt = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) rd_data <= '0;
    else if (rd_stb) rd_data <= rd_nxt;
    else rd_data <= '0;
  end

  // ==========================================================================
  // pins, registered; loopback parks them inactive
  always_ff @(posedge clk) begin
    if (rst) begin
      term_ready_pin_n   <= 1'b1;
      send_request_pin_n <= 1'b1;
      serial_tx_pin_n    <= 1'b1;
    end else begin
      // R01 R02 R24 pin levels
      term_ready_pin_n   <= loop_on | modem_control_r[uml_pkg::MCR_TERM];
      send_request_pin_n <= loop_on | modem_control_r[uml_pkg::MCR_SEND];
      serial_tx_pin_n    <= loop_on | (!lcr_r[uml_pkg::LCR_BREAK] & tx_bit);
    end
  end

  // ==========================================================================
  // checks
  term_pin_a: assert property ( // R01
    (!rst && !modem_control_r[0] && !loop_on) [*2] |-> !term_ready_pin_n)
    else $error("terminal ready pin not asserted");

  send_pin_a: assert property ( // R02
    (!rst && !modem_control_r[1] && !loop_on) [*2] |-> !send_request_pin_n)
    else $error("send request pin not asserted");

  loop_pins_a: assert property ( // R24
    loop_on |=> send_request_pin_n && term_ready_pin_n && serial_tx_pin_n)
    else $error("pins active in loopback");

  mcr_zero_a: assert property ( // R05
    rd_stb && addr == uml_pkg::OFS_MCR |=> rd_data[31:5] == 27'h0)
    else $error("control upper bits not zero");

  ready_set_a: assert property ( // R06
    rx_done && !port_rst |=> rx_data_ready_r)
    else $error("data ready not set");

  overrun_set_a: assert property ( // R07
    rx_done && rx_data_ready_r && !rd_data_q && !port_rst |=> overrun_r)
    else $error("overrun missed");

  tx_all_empty_tx_holding_empty_a: assert property ( // R12
    line_status[6] |-> line_status[5])
    else $error("all empty without holding empty");

  ring_zero_a: assert property ( // R19
    rd_msr |=> rd_data[6] == 1'b0 && rd_data[2] == 1'b0)
    else $error("ring bits not zero");

  delta_clr_a: assert property ( // R14
    rd_msr && lvl == lvl_prev_r && !port_rst |=> modem_status[3:0] == 4'h0)
    else $error("change flags not cleared by read");

  loop_cts_a: assert property ( // R16
    rd_msr && loop_on |=> rd_data[4] == $past(modem_control_r[1]))
    else $error("loopback send ready mismatch");

  loop_dsr_a: assert property ( // R17
    rd_msr && loop_on |=> rd_data[5] == $past(modem_control_r[0]))
    else $error("loopback set ready mismatch");

  loop_dcd_a: assert property ( // R18
    rd_msr && loop_on |=> rd_data[7] == $past(modem_control_r[3]))
    else $error("loopback carrier mismatch");

  soft_rst_a: assert property ( // R21
    scratch_r[uml_pkg::SCR_SRST] |=> line_status[6:5] == 2'b11 && !rx_data_ready_r)
    else $error("soft reset did not clear port");
endmodule

// file: pkg/uml_pkg.sv
/*
  Constants, field layouts and carrier types for the serial port status and modem block.
  Assumes a byte-addressed register port with 32-bit data and one system clock.
*/
package uml_pkg;
  // ==========================================================================
  // register map
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam logic [7:0]  OFS_DATA    = 8'h84;
  localparam logic [7:0]  OFS_IER_DIV = 8'h88;
  localparam logic [7:0]  OFS_LCR     = 8'h8c;
  localparam logic [7:0]  OFS_MCR     = 8'h90;
  localparam logic [7:0]  OFS_LSR     = 8'h94;
  localparam logic [7:0]  OFS_MSR     = 8'h98;
  localparam logic [7:0]  OFS_SCR     = 8'h9c;
  // ==========================================================================
  // field positions
  localparam int unsigned MCR_TERM    = 0;
  localparam int unsigned MCR_SEND    = 1;
  localparam int unsigned MCR_FLAG2   = 3;
  localparam int unsigned MCR_LOOP    = 4;
  localparam int unsigned MCR_W       = 5;
  localparam int unsigned LCR_BREAK   = 6;
  localparam int unsigned LCR_DIV_SEL = 7;
  localparam int unsigned SCR_SRST    = 8;
  localparam int unsigned IER_W       = 4;
  localparam int unsigned DIV_W       = 16;
  // ==========================================================================
  // reset values and bit timing
  localparam logic [7:0]  LCR_RST     = 8'h03;
  localparam logic [15:0] DIV_RST     = 16'h0001;
  localparam int unsigned SUB_TICKS   = 16;
  localparam int unsigned OVERSAMPLE  = 8;
  localparam int unsigned BIT_SHIFT   = $clog2(SUB_TICKS * OVERSAMPLE);
  localparam int unsigned CNT_W       = DIV_W + BIT_SHIFT;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       par_even;
    logic       par_en;
    logic       two_stop;
    logic [1:0] wls;
  } uml_frame_s;
  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
    logic       brk;
  } uml_rx_s;
  // data bits used by a word length code
  function automatic logic [3:0] uml_nbits(input logic [1:0] wls);
    return 4'h5 + {2'b00, wls};
  endfunction
endpackage

// file: rtl/uml_tx.sv
/*
  Serial transmitter: shifts one framed character out, LSB first.
  Assumes load is only honoured while idle; bit_cycles is the bit time in clocks.
*/
`timescale 1ns/1ps
module uml_tx #(
  parameter int unsigned CNT_W = uml_pkg::CNT_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [CNT_W-1:0]  bit_cycles,
  input  wire uml_pkg::uml_frame_s fmt,
  input  wire logic              load,
  input  wire logic [7:0]        data,
  output logic                   busy,
  output logic                   txd
);
  logic [11:0]      sh_r;
  logic [11:0]      frame;
  logic [3:0]       left_r;
  logic [3:0]       nbits;
  logic [CNT_W-1:0] cnt_r;

  // ==========================================================================
  // frame builder: start, data, optional parity, one or two stop bits
  always_comb begin
    frame = 12'hfff;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(uml_pkg::uml_nbits(fmt.wls))) frame[i+1] = data[i];
    end
    frame[0] = 1'b0;
    if (fmt.par_en) frame[uml_pkg::uml_nbits(fmt.wls) + 4'h1] =
      fmt.par_even ~^ (^(data & ~(8'hff << uml_pkg::uml_nbits(fmt.wls))));
    nbits = uml_pkg::uml_nbits(fmt.wls) + 4'h2 + {3'b000, fmt.par_en} + {3'b000, fmt.two_stop};
  end

  // ==========================================================================
  // R22 bit time counter
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_r   <= 12'hfff;
      left_r <= 4'h0;
      cnt_r  <= '0;
      busy   <= 1'b0;
    end else if (!busy && load) begin
      sh_r   <= frame;
      left_r <= nbits;
      cnt_r  <= bit_cycles - 1'b1;
      busy   <= 1'b1;
    end else if (busy) begin
      if (cnt_r == '0) begin
        sh_r   <= {1'b1, sh_r[11:1]};
        cnt_r  <= bit_cycles - 1'b1;
        left_r <= left_r - 4'h1;
        if (left_r == 4'h1) busy <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign txd = sh_r[0]; // flop output, idles high
endmodule

// file: rtl/uml_rx.sv
/*
  Serial receiver: finds a start bit, samples each bit at its middle, checks the frame.
  Assumes rxd is synchronous to clk; a line held low must return high before re-arming.
*/
`timescale 1ns/1ps
module uml_rx #(
  parameter int unsigned CNT_W = uml_pkg::CNT_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [CNT_W-1:0]  bit_cycles,
  input  wire uml_pkg::uml_frame_s fmt,
  input  wire logic              rxd,
  output logic                   done,
  output uml_pkg::uml_rx_s       res
);
  typedef enum logic [1:0] {UML_IDLE, UML_START, UML_BITS} uml_rx_e;
  uml_rx_e          st_r;
  logic             armed_r;
  logic [9:0]       sh_r;
  logic [9:0]       fr;
  logic [3:0]       left_r;
  logic [3:0]       nb;
  logic [3:0]       nd;
  logic [CNT_W-1:0] cnt_r;

  // ==========================================================================
  // frame alignment and checks on the last sample
  always_comb begin
    nd = uml_pkg::uml_nbits(fmt.wls);
    nb = nd + 4'h1 + {3'b000, fmt.par_en};
    fr = {rxd, sh_r[9:1]} >> (4'd10 - nb);
  end

  // ==========================================================================
  // sampling machine, mid-bit after half a bit time
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r    <= UML_IDLE;
      armed_r <= 1'b0;
      sh_r    <= '0;
      left_r  <= 4'h0;
      cnt_r   <= '0;
      done    <= 1'b0;
      res     <= '0;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        UML_IDLE: begin
          if (rxd) armed_r <= 1'b1;
          if (armed_r && !rxd) begin
            cnt_r <= bit_cycles >> 1;
            st_r  <= UML_START;
          end
        end
        UML_START: begin
          if (cnt_r != '0) cnt_r <= cnt_r - 1'b1;
          else if (rxd) st_r <= UML_IDLE; // glitch, not a start bit
          else begin
            cnt_r  <= bit_cycles - 1'b1;
            left_r <= nb;
            st_r   <= UML_BITS;
          end
        end
        UML_BITS: begin
          if (cnt_r != '0) cnt_r <= cnt_r - 1'b1;
          else begin
            sh_r   <= {rxd, sh_r[9:1]};
            cnt_r  <= bit_cycles - 1'b1;
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) begin
              // R08 R09 R10 character checks
              done        <= 1'b1;
              armed_r     <= 1'b0;
              st_r        <= UML_IDLE;
              res.data    <= fr[7:0] & ~(8'hff << nd);
              res.par_err <= fmt.par_en && (fr[nd] != (fmt.par_even ? ^(fr[7:0] & ~(8'hff << nd))
                                                                    : ~^(fr[7:0] & ~(8'hff << nd))));
              res.frm_err <= !fr[nd + {3'b000, fmt.par_en}];
              res.brk     <= (fr == 10'h000);
            end
          end
        end
      endcase
    end
  end
endmodule

// file: testbench/uml_line_model.sv
/*
  Far-side model: serial line partner and modem input pins.
  Assumes the block samples its pins on clk; bt is the bit time in clocks.
*/
`timescale 1ns/1ps
module uml_line_model (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n,
  output logic      dsr_n,
  output logic      cd_n
);
  int bt = 128;
  // idle line rests high, modem lines inactive
  initial begin
    rxd = 1'b1;
    {cts_n, dsr_n, cd_n} = 3'h7;
  end
  // ==========================================================================
  // modem lines; the wait covers the one-stage flag path
  task automatic modem(input logic c, input logic d, input logic k);
    @(posedge clk);
    {cts_n, dsr_n, cd_n} <= {c, d, k};
    repeat (3) @(posedge clk);
  endtask
  // bit time
  // frame: start, eight data bits lsb first, stop (stp=0 breaks framing)
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bt) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask
  // line low
  // held low well past a whole frame
  task automatic brk();
    @(posedge clk);
    rxd <= 1'b0;
    repeat (12 * bt) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // mid-bit sampling
  // a wrong bit time shifts samples off centre and corrupts the byte
  task automatic get(output logic [7:0] d);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      d[i] = txd;
    end
    repeat (bt) @(posedge clk);
    if (n >= 4000 || txd !== 1'b1) d = 8'hxx;
  endtask
endmodule

// file: testbench/uml_modem_line_status_regs_tb_top.sv
/*
  Self-checking bench for the serial port status and modem block.
  Assumes divisor reset of one, so a bit lasts 128 clocks.
*/
`timescale 1ns/1ps
module uml_modem_line_status_regs_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [31:0] rd_data, v;
  logic        rxd, txd, cts_n, dsr_n, cd_n, term_n, send_n;
  logic [7:0]  c;
  int          miscompares = 0;
  int          compares = 0;

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  uml_port uml_port_i (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .serial_rx_pin_n(rxd), .serial_tx_pin_n(txd),
    .clear_send_pin_n(cts_n), .set_ready_pin_n(dsr_n), .carrier_detect_pin_n(cd_n),
    .term_ready_pin_n(term_n), .send_request_pin_n(send_n));
  uml_line_model uml_line_model_i (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n),
    .dsr_n(dsr_n), .cd_n(cd_n));

  // ==========================================================================
  // register port and compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wr_data <= d; wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    rd(a, d);
    chk(d, e, m);
  endtask
  task automatic pins(input logic [31:0] e);
    repeat (2) @(posedge clk);
    #1 chk({30'h0, term_n, send_n}, e, "modem pins");
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rdc(8'h94, 32'h60, "line status");
    rdc(8'h90, 32'h0, "modem control");
    rdc(8'h98, 32'h0, "modem status");
    rdc(8'h00, 32'h0, "unmapped");
    chk({30'h0, term_n, send_n}, 32'h0, "pins idle");
  endtask
  task automatic t_mcr();
    wr(8'h90, 32'hffffffec);
    rdc(8'h90, 32'hc, "flags only");
    pins(32'h0);
    wr(8'h90, 32'h1);
    pins(32'h2);
    wr(8'h90, 32'h2);
    pins(32'h1);
  endtask
  task automatic t_msr();
    uml_line_model_i.modem(1'b0, 1'b1, 1'b1);
    rdc(8'h98, 32'h11, "send clear");
    rdc(8'h98, 32'h10, "flag cleared");
    uml_line_model_i.modem(1'b0, 1'b0, 1'b0);
    rdc(8'h98, 32'hba, "ready carrier");
    uml_line_model_i.modem(1'b1, 1'b1, 1'b1);
    rdc(8'h98, 32'h0b, "all dropped");
    rdc(8'h98, 32'h0, "quiet");
  endtask
  // loss of data keeps the older character
  task automatic t_rx();
    uml_line_model_i.send(8'h3c, 1'b1);
    repeat (4) @(posedge clk);
    rdc(8'h94, 32'h61, "ready");
    rdc(8'h84, 32'h3c, "rx byte");
    rdc(8'h94, 32'h60, "empty");
    uml_line_model_i.send(8'h55, 1'b0);
    repeat (4) @(posedge clk);
    rdc(8'h94, 32'he9, "framing");
    rd(8'h84, v);
    rdc(8'h94, 32'h60, "errors gone");
    uml_line_model_i.send(8'h11, 1'b1);
    uml_line_model_i.send(8'h22, 1'b1);
    repeat (4) @(posedge clk);
    rdc(8'h94, 32'h63, "overrun");
    rdc(8'h84, 32'h11, "older kept");
    uml_line_model_i.brk();
    repeat (4) @(posedge clk);
    rd(8'h94, v);
    chk(v & 32'hf7, 32'hf1, "break");
    rd(8'h84, v);
  endtask
  task automatic t_tx(input logic [7:0] a, input logic [7:0] b);
    wr(8'h84, {24'h0, a});
    wr(8'h84, {24'h0, b});
    rd(8'h94, v);
    chk(v & 32'h60, 32'h0, "tx busy");
    uml_line_model_i.get(c);
    chk({24'h0, c}, {24'h0, a}, "tx first");
    uml_line_model_i.get(c);
    chk({24'h0, c}, {24'h0, b}, "tx second");
    repeat (400) @(posedge clk);
    rdc(8'h94, 32'h60, "tx idle");
  endtask
  task automatic t_div();
    wr(8'h8c, 32'h83);
    wr(8'h88, 32'h2);
    wr(8'h8c, 32'h1b);
    rdc(8'h88, 32'h0, "enable untouched");
    uml_line_model_i.bt = 256;
    t_tx(8'h07, 8'h15);
    uml_line_model_i.send(8'h3c, 1'b1);
    repeat (400) @(posedge clk);
    rdc(8'h94, 32'he5, "parity");
    rdc(8'h84, 32'h3c, "parity byte");
    uml_line_model_i.bt = 128;
    wr(8'h8c, 32'h83);
    wr(8'h88, 32'h1);
    wr(8'h8c, 32'h03);
  endtask
  task automatic t_loop();
    wr(8'h90, 32'h1b);
    pins(32'h3);
    rd(8'h98, v);
    chk(v & 32'hf4, 32'hb0, "loop levels");
    wr(8'h84, 32'ha5);
    v = 32'h0;
    for (int i = 0; i < 1000 && !v[0]; i++) rd(8'h94, v);
    chk(v & 32'h1, 32'h1, "looped rx");
    rdc(8'h84, 32'ha5, "looped byte");
    wr(8'h90, 32'h0);
  endtask
  task automatic t_srst();
    wr(8'h9c, 32'h1a5);
    rdc(8'h9c, 32'h1a5, "scratch held");
    wr(8'h84, 32'h77);
    v = 32'h1;
    repeat (300) begin
      @(posedge clk);
      v[0] = v[0] & txd;
    end
    chk(v, 32'h1, "tx held off");
    rdc(8'h94, 32'h60, "status held");
    wr(8'h9c, 32'ha5);
    rdc(8'h9c, 32'ha5, "scratch");
  endtask

  // ==========================================================================
  // verdict, main sequence and watchdog
  task automatic wrap_up();
    $display("miscompares=%0d compares=%0d", miscompares, compares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_mcr();
    t_msr();
    t_rx();
    t_tx(8'h5a, 8'hc3);
    t_div();
    t_loop();
    t_srst();
    wrap_up();
  end
  // run needs about 20k clocks; cut a hang well beyond that
  initial begin
    #900us;
    miscompares++;
    wrap_up();
  end
endmodule
